// *** pkg/drs_pkg.sv ***
// Purpose: Constants and types for the reference selection block
// Assumes: 25 MHz ref_clk
// Notes: Register offsets are word byte addresses on the plain port
package drs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRIO = 8'h04;
  localparam logic [7:0] REG_MON = 8'h08;
  localparam logic [7:0] REG_VTIMER = 8'h0c;
  localparam logic [7:0] REG_SLEW = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_OFFSET = 8'h18;
  // CTRL fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MAN_SEL = 2;
  localparam int CTRL_PIN_SEL = 3;
  localparam int CTRL_HITLESS = 4;
  localparam int CTRL_SLEW_EN = 5;
  localparam int CTRL_XO_BYP = 6;
  localparam int CTRL_ZDS = 7;
  localparam int CTRL_PPS = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  // PRIO fields: input zero in [2:0], input one in [6:4]
  localparam int PRIO_W = 3;
  localparam int PRIO_ONE_LSB = 4;
  localparam logic [2:0] PRIO_RST = 3'h1;
  localparam logic [2:0] PRIO_NONE = 3'h0;
  // MON: per input 4 enables (freq, miss, runt, phase), input one at bit 4
  localparam int MON_W = 4;
  localparam int MON_ONE_LSB = 4;
  localparam logic [3:0] MON_RST = 4'h3;
  localparam logic [15:0] VTIMER_RST = 16'h0010;
  localparam logic [15:0] SLEW_STEP_RST = 16'h0001;
  localparam logic [15:0] SLEW_TIMER_RST = 16'h0010;
  // XO window, kHz
  localparam int XO_MIN_KHZ = 9000;
  localparam int XO_MAX_KHZ = 160000;
  localparam int PH_W = 16;

  typedef enum logic [1:0] {
    DRS_AUTO_REV = 2'b00,
    DRS_AUTO_NONREV = 2'b01,
    DRS_MAN_FALLBACK = 2'b10,
    DRS_MAN_HOLDOVER = 2'b11
  } drs_mode_e;

  typedef enum logic [1:0] {
    DRS_FREE_RUN = 2'b00,
    DRS_LOCKED = 2'b01,
    DRS_HOLDOVER = 2'b10
  } drs_loop_e;
endpackage

// *** design/drs_ref_select.sv ***
// Purpose: Two-input reference qualification, selection and hitless phase handling
// Assumes: Monitor flags and phase measures arrive synchronous to ref_clk
// Notes: Detector algorithms lie outside; only their flags come in
// How it works
// - Priority 0..7 per input, 0 never selected
// - Equal priority prefers input zero
// - Revertive: always best valid input
// - Non-revertive: hold current until it fails
// - Manual choice from register or pin
// - Fallback: manual failure picks best valid
// - None valid: holdover if history, else free-run
// - Auto-holdover: manual failure goes straight holdover
// - Manual modes leave holdover when selection valid
// - Selected input readable and on pins
// - Hitless off: offset passes as step
// - Cancellation without slew keeps offset forever
// - Non-locked switches move under slew
// - Slew removes offset by step per timer
// - Slew also on holdover exit, non-locked switch
// - PPS hitless only without zero-delay sync
// - XO loss flag clear only 9..160 MHz
// - Bypass makes XO valid, flag unchanged
// - Qualify after enabled monitors clear for timer
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module drs_ref_select
  import drs_pkg::*;
#(
  parameter int VT_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // Monitor flags per input: [3]phase [2]runt [1]miss [0]freq
  input wire logic [3:0] mon_flag_zero,
  input wire logic [3:0] mon_flag_one,
  // XO measurement in kHz and history state
  input wire logic [17:0] xo_freq_khz,
  input wire logic history_valid,
  input wire logic inputs_freq_locked,
  // Phase offset seen between old and new input at a switch
  input wire logic signed [PH_W-1:0] switch_phase_offset,
  // Manual select pin
  input wire logic manual_sel_pin,
  // Status outputs
  output logic selected_ref,
  output logic loop_locked,
  output logic loop_holdover,
  output logic xo_frequency_loss_flag,
  output logic xo_valid,
  output logic signed [PH_W-1:0] phase_correction,
  output logic switch_pulse
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] prio0;
    logic [2:0] prio1;
    logic [7:0] mon_en;
    logic [VT_W-1:0] vtimer;
    logic [15:0] slew_step;
    logic [15:0] slew_timer;
    logic [VT_W-1:0] vcnt0;
    logic [VT_W-1:0] vcnt1;
    logic qual0;
    logic qual1;
    logic sel;
    drs_loop_e loop;
    logic xo_loss;
    logic signed [PH_W-1:0] offset;
    logic [15:0] slew_cnt;
    logic sw;
    logic [DATA_W-1:0] rdata;
  } drs_state_s;

  drs_state_s s_reg, s_next;

  // Better of two inputs by priority, ties go to input zero
  function automatic logic pick_best(input logic [2:0] p0, input logic [2:0] p1,
                                     input logic v0, input logic v1);
    logic ok0;
    logic ok1;
    ok0 = v0 && (p0 != PRIO_NONE);
    ok1 = v1 && (p1 != PRIO_NONE);
    if (ok0 && ok1)
      pick_best = (p1 < p0);
    else
      pick_best = !ok0 && ok1;
  endfunction

  function automatic logic any_valid(input logic [2:0] p0, input logic [2:0] p1,
                                     input logic v0, input logic v1);
    any_valid = (v0 && (p0 != PRIO_NONE)) || (v1 && (p1 != PRIO_NONE));
  endfunction

  // Qualified and not excluded by a zero priority
  function automatic logic usable(input logic which,
                                  input logic [2:0] p0, input logic [2:0] p1,
                                  input logic v0, input logic v1);
    usable = which ? (v1 && (p1 != PRIO_NONE)) : (v0 && (p0 != PRIO_NONE));
  endfunction

  logic [3:0] eff0, eff1;
  logic clear0, clear1;
  logic best, has_valid, cur_valid, man_sel, man_valid;
  logic new_sel, new_ok;
  drs_mode_e mode;

  always_comb begin
    s_next = s_reg;
    mode = drs_mode_e'(s_reg.ctrl[CTRL_MODE_LSB +: 2]);
    // Disabled monitors are masked out
    eff0 = mon_flag_zero & s_reg.mon_en[MON_W-1:0];
    eff1 = mon_flag_one & s_reg.mon_en[MON_ONE_LSB +: MON_W];
    clear0 = (eff0 == 4'h0);
    clear1 = (eff1 == 4'h0);
    // Validation timers
    if (!clear0) begin
      s_next.vcnt0 = '0;
      s_next.qual0 = 1'b0;
    end else if (s_reg.vcnt0 >= s_reg.vtimer) begin
      s_next.qual0 = 1'b1;
    end else begin
      s_next.vcnt0 = s_reg.vcnt0 + 1'b1;
    end
    if (!clear1) begin
      s_next.vcnt1 = '0;
      s_next.qual1 = 1'b0;
    end else if (s_reg.vcnt1 >= s_reg.vtimer) begin
      s_next.qual1 = 1'b1;
    end else begin
      s_next.vcnt1 = s_reg.vcnt1 + 1'b1;
    end
    // XO coarse range
    s_next.xo_loss = !((xo_freq_khz >= 18'(XO_MIN_KHZ)) &&
                       (xo_freq_khz <= 18'(XO_MAX_KHZ)));
    best = pick_best(s_reg.prio0, s_reg.prio1, s_reg.qual0, s_reg.qual1);
    has_valid = any_valid(s_reg.prio0, s_reg.prio1, s_reg.qual0, s_reg.qual1);
    cur_valid = usable(s_reg.sel, s_reg.prio0, s_reg.prio1, s_reg.qual0, s_reg.qual1);
    man_sel = s_reg.ctrl[CTRL_PIN_SEL] ? manual_sel_pin : s_reg.ctrl[CTRL_MAN_SEL];
    man_valid = usable(man_sel, s_reg.prio0, s_reg.prio1, s_reg.qual0, s_reg.qual1);
    new_sel = s_reg.sel;
    new_ok = 1'b0;
    case (mode)
      DRS_AUTO_REV: begin
        new_sel = best;
        new_ok = has_valid;
      end
      DRS_AUTO_NONREV: begin
        if (s_reg.loop == DRS_LOCKED && cur_valid) begin
          new_ok = 1'b1;
        end else begin
          new_sel = best;
          new_ok = has_valid;
        end
      end
      DRS_MAN_FALLBACK: begin
        if (man_valid) begin
          new_sel = man_sel;
          new_ok = 1'b1;
        end else begin
          new_sel = best;
          new_ok = has_valid;
        end
      end
      DRS_MAN_HOLDOVER: begin
        new_sel = man_sel;
        new_ok = man_valid;
      end
      default: begin
        new_ok = 1'b0;
      end
    endcase
    // XO must be valid before any lock
    if (!(s_reg.xo_loss == 1'b0 || s_reg.ctrl[CTRL_XO_BYP]))
      new_ok = 1'b0;
    s_next.sw = 1'b0;
    if (new_ok) begin
      if (s_reg.loop != DRS_LOCKED || new_sel != s_reg.sel) begin
        s_next.sw = 1'b1;
        // Absorb offset when hitless is allowed, or with slew on a non-locked switch
        if (s_reg.ctrl[CTRL_HITLESS] && !(s_reg.ctrl[CTRL_PPS] && s_reg.ctrl[CTRL_ZDS]) &&
            s_reg.loop == DRS_LOCKED)
          s_next.offset = switch_phase_offset;
        else
          s_next.offset = '0;
        if (s_reg.ctrl[CTRL_SLEW_EN] && (s_reg.loop != DRS_LOCKED || !inputs_freq_locked))
          s_next.offset = switch_phase_offset;
      end
      s_next.sel = new_sel;
      s_next.loop = DRS_LOCKED;
    end else begin
      s_next.loop = history_valid ? DRS_HOLDOVER : DRS_FREE_RUN;
    end
    // Gradual removal of absorbed phase
    if (s_reg.ctrl[CTRL_SLEW_EN] && !s_next.sw && s_reg.offset != '0) begin
      if (s_reg.slew_cnt >= s_reg.slew_timer) begin
        s_next.slew_cnt = '0;
        if (s_reg.offset > $signed(s_reg.slew_step[PH_W-1:0]))
          s_next.offset = s_reg.offset - $signed(s_reg.slew_step[PH_W-1:0]);
        else if (s_reg.offset < -$signed(s_reg.slew_step[PH_W-1:0]))
          s_next.offset = s_reg.offset + $signed(s_reg.slew_step[PH_W-1:0]);
        else
          s_next.offset = '0;
      end else begin
        s_next.slew_cnt = s_reg.slew_cnt + 1'b1;
      end
    end else begin
      s_next.slew_cnt = '0;
    end
    // Register writes
    if (wr_en) begin
      case (addr)
        REG_CTRL: s_next.ctrl = wdata;
        REG_PRIO: begin
          s_next.prio0 = wdata[PRIO_W-1:0];
          s_next.prio1 = wdata[PRIO_ONE_LSB +: PRIO_W];
        end
        REG_MON: s_next.mon_en = wdata[7:0];
        REG_VTIMER: s_next.vtimer = wdata[VT_W-1:0];
        REG_SLEW: begin
          s_next.slew_step = wdata[15:0];
          s_next.slew_timer = wdata[31:16];
        end
        default: ;
      endcase
    end
    // Register reads, data stands one cycle later
    s_next.rdata = '0;
    if (rd_en) begin
      case (addr)
        REG_CTRL: s_next.rdata = s_reg.ctrl;
        REG_PRIO: s_next.rdata = {25'h0, s_reg.prio1, 1'b0, s_reg.prio0};
        REG_MON: s_next.rdata = {24'h0, s_reg.mon_en};
        REG_VTIMER: s_next.rdata = 32'(s_reg.vtimer);
        REG_SLEW: s_next.rdata = {s_reg.slew_timer, s_reg.slew_step};
        REG_STATUS: s_next.rdata = {24'h0, s_reg.xo_loss, s_reg.qual1, s_reg.qual0,
                                    1'b0, s_reg.loop, 1'b0, s_reg.sel};
        REG_OFFSET: s_next.rdata = 32'(s_reg.offset);
        default: s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.prio0 <= PRIO_RST;
      s_reg.prio1 <= PRIO_RST;
      s_reg.mon_en <= {MON_RST, MON_RST};
      s_reg.vtimer <= VT_W'(VTIMER_RST);
      s_reg.slew_step <= SLEW_STEP_RST;
      s_reg.slew_timer <= SLEW_TIMER_RST;
      s_reg.loop <= DRS_FREE_RUN;
      s_reg.xo_loss <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign selected_ref = s_reg.sel;
  assign loop_locked = (s_reg.loop == DRS_LOCKED);
  assign loop_holdover = (s_reg.loop == DRS_HOLDOVER);
  assign xo_frequency_loss_flag = s_reg.xo_loss;
  assign xo_valid = !s_reg.xo_loss || s_reg.ctrl[CTRL_XO_BYP];
  assign phase_correction = s_reg.offset;
  assign switch_pulse = s_reg.sw;

  // ==========================================================
  // Checks
  property p_never_prio0;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(loop_locked) |-> (selected_ref ? $past(s_reg.prio1) : $past(s_reg.prio0)) != 3'h0;
  endproperty
  a_never_prio0: assert property (p_never_prio0) else $error("zero priority selected");

  property p_tie;
    @(posedge ref_clk) disable iff (!arst_n)
      (s_reg.ctrl[1:0] == 2'b00 && s_reg.qual0 && s_reg.qual1 && s_reg.prio0 == s_reg.prio1
       && s_reg.prio0 != 3'h0 && xo_valid) |=> !selected_ref;
  endproperty
  a_tie: assert property (p_tie) else $error("tie not resolved to input zero");

  property p_nonrev_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      (s_reg.ctrl[1:0] == 2'b01 && loop_locked && cur_valid && xo_valid && !wr_en)
      |=> $stable(selected_ref);
  endproperty
  a_nonrev_hold: assert property (p_nonrev_hold) else $error("non-revertive switched");

  property p_holdover;
    @(posedge ref_clk) disable iff (!arst_n)
      (!new_ok && history_valid) |=> loop_holdover;
  endproperty
  a_holdover: assert property (p_holdover) else $error("holdover not entered");

  property p_free;
    @(posedge ref_clk) disable iff (!arst_n)
      (!new_ok && !history_valid) |=> (!loop_locked && !loop_holdover);
  endproperty
  a_free: assert property (p_free) else $error("free-run not entered");

  property p_xo_range;
    @(posedge ref_clk) disable iff (!arst_n)
      (xo_freq_khz < 18'(XO_MIN_KHZ)) |=> xo_frequency_loss_flag;
  endproperty
  a_xo_range: assert property (p_xo_range) else $error("xo loss not set");

  property p_qual;
    @(posedge ref_clk) disable iff (!arst_n)
      !clear0 |=> !s_reg.qual0 ##1 (!s_reg.qual0 || $past(clear0));
  endproperty
  a_qual: assert property (p_qual) else $error("input zero qualified early");

  property p_slew_mono;
    @(posedge ref_clk) disable iff (!arst_n)
      (s_reg.ctrl[CTRL_SLEW_EN] && !s_next.sw && !switch_pulse && s_reg.offset > 0 && !wr_en)
      |=> (s_reg.offset <= $past(s_reg.offset));
  endproperty
  a_slew_mono: assert property (p_slew_mono) else $error("slew grew offset");

  property p_hold_keep;
    @(posedge ref_clk) disable iff (!arst_n)
      (!s_reg.ctrl[CTRL_SLEW_EN] && !s_next.sw) |=> $stable(phase_correction);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("build-out removed");
endmodule

// *** sim/drs_ref_src.sv ***
// Purpose: Far-side model of the two reference sources and their monitors
// Assumes: Fault requests come from the bench, synchronous to ref_clk
// Notes: All flags are raised while in reset, no source qualified yet
`timescale 1ns/100ps
module drs_ref_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Fault requests per input
  input wire logic [3:0] fault_zero,
  input wire logic [3:0] fault_one,
  // Monitor flags
  output logic [3:0] mon_flag_zero,
  output logic [3:0] mon_flag_one
);
  // ==========================================
  // Flag generation
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_flag_zero <= 4'hf;
      mon_flag_one <= 4'hf;
    end else begin
      // All four monitor faults (freq, miss, runt, phase) only as commanded
      mon_flag_zero <= fault_zero;
      mon_flag_one <= fault_one;
    end
  end
endmodule

// *** sim/drs_ref_select_tb.sv ***
// Purpose: Self-checking bench for reference selection
// Assumes: 25 MHz ref_clk, register port with one-cycle read data
// Notes: Validation timer shortened to keep waits short
`timescale 1ns/100ps
module drs_ref_select_tb;
  import drs_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [3:0] mon_flag_zero, mon_flag_one;
  logic [3:0] fault_zero = 4'h0;
  logic [3:0] fault_one = 4'h0;
  logic [17:0] xo_freq_khz = 18'd25000;
  logic history_valid = 1'b1;
  logic inputs_freq_locked = 1'b1;
  logic signed [PH_W-1:0] switch_phase_offset = 16'sh0040;
  logic manual_sel_pin = 1'b0;
  logic selected_ref, loop_locked, loop_holdover, xo_frequency_loss_flag, xo_valid, switch_pulse;
  logic signed [PH_W-1:0] phase_correction, pc_seen;
  logic [DATA_W-1:0] rd;
  int failures = 0;
  int check_count = 0;
  int xo_tab [4] = '{8999, 9000, 160000, 160001};
  logic xo_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  always #20 ref_clk = ~ref_clk;

  drs_ref_src src (.ref_clk(ref_clk), .arst_n(arst_n), .fault_zero(fault_zero),
    .fault_one(fault_one), .mon_flag_zero(mon_flag_zero), .mon_flag_one(mon_flag_one));

  drs_ref_select dut (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mon_flag_zero(mon_flag_zero),
    .mon_flag_one(mon_flag_one), .xo_freq_khz(xo_freq_khz), .history_valid(history_valid),
    .inputs_freq_locked(inputs_freq_locked), .switch_phase_offset(switch_phase_offset),
    .manual_sel_pin(manual_sel_pin), .selected_ref(selected_ref), .loop_locked(loop_locked),
    .loop_holdover(loop_holdover), .xo_frequency_loss_flag(xo_frequency_loss_flag),
    .xo_valid(xo_valid), .phase_correction(phase_correction), .switch_pulse(switch_pulse));

  // ==========================================
  // Access and compare tasks
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait on selected_ref (0), loop_holdover (1) or loop_locked (2)
  task automatic wait_on(input int which, input logic v);
    logic s;
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      #1;
      s = (which == 0) ? selected_ref : (which == 1) ? loop_holdover : loop_locked;
      if (s === v) return;
    end
    failures++;
    $display("ERROR %0t wait %0d timed out", $time, which);
    results();
  endtask

  // ==========================================
  // Scenarios
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    reg_rd(REG_CTRL, rd);
    chk32(rd, CTRL_RST);
    reg_rd(REG_PRIO, rd);
    chk32(rd, 32'h0000_0011);
    reg_rd(REG_MON, rd);
    chk32(rd, 32'h0000_0033);
    reg_rd(REG_VTIMER, rd);
    chk32(rd, 32'h0000_0010);
    reg_rd(REG_SLEW, rd);
    chk32(rd, 32'h0010_0001);
    reg_rd(8'h1c, rd);
    chk32(rd, 32'h0);
    reg_wr(REG_VTIMER, 32'h4);
    reg_wr(REG_CTRL, 32'h0);
    reg_wr(REG_PRIO, 32'h12);
    wait_on(0, 1'b1);
    chk1(switch_pulse, 1'b1);
    chk32(32'(phase_correction), 32'h0);
    wait_on(2, 1'b1);
    reg_rd(REG_STATUS, rd);
    chk32(rd & 32'h0d, 32'h05);
    reg_wr(REG_PRIO, 32'h11);
    wait_on(0, 1'b0);
    reg_wr(REG_PRIO, 32'h21);
    reg_wr(REG_CTRL, 32'h1);
    fault_zero <= 4'h1;
    wait_on(0, 1'b1);
    fault_zero <= 4'h0;
    cycles(30);
    chk1(selected_ref, 1'b1);
    reg_wr(REG_PRIO, 32'h01);
    reg_wr(REG_CTRL, 32'h0);
    wait_on(0, 1'b0);
    fault_zero <= 4'h1;
    wait_on(1, 1'b1);
    fault_zero <= 4'h0;
    reg_wr(REG_PRIO, 32'h21);
    reg_wr(REG_CTRL, 32'h6);
    wait_on(0, 1'b1);
    fault_one <= 4'h2;
    wait_on(0, 1'b0);
    fault_one <= 4'h0;
    manual_sel_pin <= 1'b1;
    reg_wr(REG_CTRL, 32'ha);
    wait_on(0, 1'b1);
    manual_sel_pin <= 1'b0;
    wait_on(0, 1'b0);
    reg_wr(REG_CTRL, 32'h7);
    wait_on(0, 1'b1);
    wait_on(2, 1'b1);
    fault_one <= 4'h1;
    wait_on(1, 1'b1);
    chk1(selected_ref, 1'b1);
    fault_one <= 4'h0;
    wait_on(2, 1'b1);
    chk1(loop_holdover, 1'b0);
    reg_wr(REG_CTRL, 32'h12);
    wait_on(0, 1'b0);
    cycles(10);
    pc_seen = phase_correction;
    chk32(32'(pc_seen), 32'h0000_0040);
    cycles(150);
    chk32(32'(phase_correction), 32'(pc_seen));
    reg_rd(REG_OFFSET, rd);
    chk32(rd, 32'h0000_0040);
    fault_zero <= 4'h8;
    cycles(30);
    reg_rd(REG_STATUS, rd);
    chk1(rd[5], 1'b1);
    chk1(selected_ref, 1'b0);
    fault_zero <= 4'h0;
    foreach (xo_tab[i]) begin
      xo_freq_khz <= 18'(xo_tab[i]);
      cycles(4);
      chk1(xo_frequency_loss_flag, xo_exp[i]);
    end
    reg_wr(REG_CTRL, 32'h52);
    cycles(3);
    chk1(xo_valid, 1'b1);
    chk1(xo_frequency_loss_flag, 1'b1);
    chk1(loop_locked, 1'b1);
    // Slew removes a hitless build-out step by step
    reg_wr(REG_SLEW, 32'h0002_0010);
    reg_wr(REG_CTRL, 32'h76);
    wait_on(0, 1'b1);
    chk32(32'(phase_correction), 32'h0000_0040);
    cycles(3);
    chk32(32'(phase_correction), 32'h0000_0030);
    cycles(20);
    chk32(32'(phase_correction), 32'h0);
    // Non-locked switch with slew, hitless off
    inputs_freq_locked <= 1'b0;
    reg_wr(REG_CTRL, 32'h62);
    wait_on(0, 1'b0);
    chk32(32'(phase_correction), 32'h0000_0040);
    inputs_freq_locked <= 1'b1;
    cycles(20);
    chk32(32'(phase_correction), 32'h0);
    // Holdover exit with slew
    reg_wr(REG_CTRL, 32'h63);
    fault_zero <= 4'h1;
    wait_on(1, 1'b1);
    fault_zero <= 4'h0;
    wait_on(2, 1'b1);
    chk32(32'(phase_correction), 32'h0000_0040);
    // Pulse-per-second inputs, phase monitor only
    reg_wr(REG_MON, 32'h88);
    wait_on(2, 1'b1);
    reg_wr(REG_CTRL, 32'h1d6);
    wait_on(0, 1'b1);
    chk32(32'(phase_correction), 32'h0);
    wait_on(2, 1'b1);
    reg_wr(REG_CTRL, 32'h152);
    wait_on(0, 1'b0);
    chk32(32'(phase_correction), 32'h0000_0040);
    results();
  end
endmodule
